// *** sim/dcf_ctrl_props.sv ***
`timescale 1ns/1ns
module dcf_ctrl_props (
	input wire logic                   CLK,
	input wire logic                   ARST_N,
	input wire logic                   IO_UPDATE,
	input wire logic                   RAMP_TIMER_AT_ONE,
	input wire logic [31:0]            RD_DATA,
	input wire logic                   SDIO_OE_N,
	input wire logic                   SDO_O,
	input wire dcf_pkg::dcf_core_type  CORE,
	input wire dcf_pkg::dcf_pulse_type PULSE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!ARST_N);
	a_update_only: assert property ($changed(RD_DATA) |-> $past(IO_UPDATE, 2))
		else $error("active copy moved without an update");
	a_masked_zero: assert property ((RD_DATA & ~dcf_pkg::CFR_WR_MASK) == '0 && !RD_DATA[22])
		else $error("unstored bit reads one");
	a_sync_once: assert property (PULSE.sync_advance |=> !PULSE.sync_advance)
		else $error("sync advance longer than one cycle");
	a_ram_off: assert property (!RD_DATA[31] |-> !CORE.ram_en && CORE.ram_mode == '0
		&& CORE.src == dcf_pkg::DCF_SRC_TONE_SWEEP) else $error("ram off but ram path active");
	a_ram_dest: assert property (RD_DATA[31] |-> CORE.ram_en && CORE.src == (RD_DATA[30] ?
		dcf_pkg::DCF_SRC_RAM_PHASE : dcf_pkg::DCF_SRC_RAM_FREQ)) else $error("ram route wrong");
	a_keying_mode: assert property (CORE.osk == (!RD_DATA[25] ? dcf_pkg::DCF_OSK_BYPASS :
		RD_DATA[24] ? dcf_pkg::DCF_OSK_AUTO : dcf_pkg::DCF_OSK_MANUAL)) else $error("keying mode");
	a_dither_map: assert property ({CORE.amp_dither_en, CORE.phase_dither_en} == RD_DATA[20:16])
		else $error("dither enables differ from register");
	a_level_map: assert property ({CORE.auto_sync_en, CORE.sine_sel, CORE.freq_acc_clr,
		CORE.phase_acc_clr} == {RD_DATA[23], RD_DATA[12:10]}) else $error("core level differs");
	a_zero_cause: assert property ((PULSE.freq_acc_zero |-> RD_DATA[14]) and
		(PULSE.phase_acc_zero |-> RD_DATA[13])) else $error("accumulator zero without its bit");
	a_ramp_cause: assert property (PULSE.ramp_reload |-> $past(RAMP_TIMER_AT_ONE) || RD_DATA[26])
		else $error("ramp reload without cause");
	a_pin_dir: assert property (RD_DATA[9] ? SDIO_OE_N : !SDO_O)
		else $error("serial pin direction wrong");
endmodule
bind dcf_ctrl dcf_ctrl_props dcf_ctrl_props_inst (.CLK, .ARST_N, .IO_UPDATE, .RAMP_TIMER_AT_ONE,
	.RD_DATA, .SDIO_OE_N, .SDO_O, .CORE, .PULSE);

// *** sim/testbench.sv ***
`timescale 1ns/1ns
module testbench;
	logic                       CLK, ARST_N, WR_EN, IO_UPDATE, PROFILE_STEP;
	logic                       RAMP_TIMER_AT_ONE, SER_OUT_BIT, SER_OUT_EN;
	logic                       SDIO_O, SDIO_OE_N, SDO_O;
	logic [31:0]                WR_DATA, RD_DATA;
	logic [dcf_pkg::SEL_W-1:0]  PROFILE_PINS;
	logic [dcf_pkg::MODE_W-1:0] SEG_MODE;
	dcf_pkg::dcf_core_type      CORE;
	dcf_pkg::dcf_pulse_type     PULSE;
	int                         fail_count, num_checks, n_sy, n_fz, n_pz, n_rr;
	dcf_ctrl dcf_ctrl_inst (.CLK, .ARST_N, .WR_EN, .WR_DATA, .RD_DATA, .IO_UPDATE,
		.PROFILE_PINS, .PROFILE_STEP, .SEG_MODE, .RAMP_TIMER_AT_ONE, .SER_OUT_BIT,
		.SER_OUT_EN, .SDIO_O, .SDIO_OE_N, .SDO_O, .CORE, .PULSE);
	// Pulses last one cycle, so they are counted at every edge rather than sampled once.
	always @(posedge CLK) begin
		n_sy += PULSE.sync_advance;
		n_fz += PULSE.freq_acc_zero;
		n_pz += PULSE.phase_acc_zero;
		n_rr += PULSE.ramp_reload;
	end
	initial begin
		CLK = 1'b0;
		forever #10 CLK = ~CLK;
	end
	////////////////////////////////////////
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [31:0] d);
		@(posedge CLK);
		WR_EN <= 1'b1;
		WR_DATA <= d;
		@(posedge CLK);
		WR_EN <= 1'b0;
	endtask
	task automatic upd;
		@(posedge CLK);
		{n_sy, n_fz, n_pz, n_rr} = '0;
		IO_UPDATE <= 1'b1;
		repeat (5) @(posedge CLK);
		IO_UPDATE <= 1'b0;
		repeat (4) @(posedge CLK);
	endtask
	task automatic t_fields;
		logic [31:0] v [8] = '{32'h0, 32'h8000_0000, 32'hC000_0000, 32'h4000_0000,
			32'h0100_0000, 32'h0300_0000, 32'h009F_1C00, 32'h0640_6000};
		logic [31:0] prev;
		prev = 32'h0;
		foreach (v[i]) begin
			wr(v[i]);
			chk(RD_DATA, prev);
			upd();
			prev = v[i] & ~32'h0040_0000;
			chk(RD_DATA, prev);
			chk(CORE.src, !v[i][31] ? dcf_pkg::DCF_SRC_TONE_SWEEP : v[i][30] ?
				dcf_pkg::DCF_SRC_RAM_PHASE : dcf_pkg::DCF_SRC_RAM_FREQ);
			chk({CORE.ram_en, CORE.ram_mode}, v[i][31] ? 4'hD : 4'h0);
			chk(CORE.osk, !v[i][25] ? dcf_pkg::DCF_OSK_BYPASS : v[i][24] ?
				dcf_pkg::DCF_OSK_AUTO : dcf_pkg::DCF_OSK_MANUAL);
			chk({CORE.auto_sync_en, CORE.amp_dither_en, CORE.phase_dither_en, CORE.sine_sel,
				CORE.freq_acc_clr, CORE.phase_acc_clr}, {v[i][23], v[i][20:16], v[i][12:10]});
			chk({n_sy[7:0], n_fz[7:0], n_pz[7:0], n_rr[7:0]}, {7'h0, v[i][22], 7'h0, v[i][14],
				7'h0, v[i][13], 7'h0, v[i][26]});
		end
		// A repeated update without a write must not advance the sync edge again.
		upd();
		chk({n_sy[7:0], n_fz[7:0], n_pz[7:0], n_rr[7:0]}, 32'h0001_0101);
		$display("t_fields done");
	endtask
	task automatic t_serial;
		SER_OUT_EN <= 1'b1;
		SER_OUT_BIT <= 1'b1;
		repeat (3) @(posedge CLK);
		chk({SDIO_OE_N, SDIO_O, SDO_O}, 3'h2);
		wr(32'h0000_0200);
		upd();
		chk({SDIO_OE_N, SDO_O}, 2'h3);
		$display("t_serial done");
	endtask
	task automatic t_profile;
		PROFILE_PINS <= 2'h2;
		repeat (5) @(posedge CLK);
		chk({CORE.int_prof, CORE.prof_sel}, 3'h2);
		wr(32'h0800_0000);
		upd();
		for (int i = 0; i < 3; i++) begin
			chk({CORE.int_prof, CORE.prof_sel}, (i == 1) ? 3'h5 : 3'h4);
			PROFILE_STEP <= 1'b1;
			@(posedge CLK);
			PROFILE_STEP <= 1'b0;
			repeat (2) @(posedge CLK);
		end
		n_rr = 0;
		RAMP_TIMER_AT_ONE <= 1'b1;
		@(posedge CLK);
		RAMP_TIMER_AT_ONE <= 1'b0;
		repeat (3) @(posedge CLK);
		chk(n_rr, 1);
		$display("t_profile done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	////////////////////////////////////////
	initial begin
		{ARST_N, WR_EN, IO_UPDATE, PROFILE_STEP, RAMP_TIMER_AT_ONE, SER_OUT_BIT, SER_OUT_EN} = '0;
		{WR_DATA, PROFILE_PINS} = '0;
		SEG_MODE = 3'h5;
		{fail_count, num_checks} = '0;
		repeat (8) @(posedge CLK);
		chk(RD_DATA, 32'h0000_0000);
		chk({SDIO_OE_N, CORE, PULSE}, 32'h0100_0000);
		ARST_N <= 1'b1;
		t_fields();
		t_serial();
		t_profile();
		tally_and_finish();
	end
endmodule

// *** src/dcf_ctrl.sv ***
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// Operation
// RL1 - RAM off: single tone or sweep.
// RL2 - RAM on: mode from selected profile word.
// RL3 - Destination picks frequency or phase path.
// RL4 - Internal profile field overrides external selects.
// RL5 - Ramp timer reloads at one, optionally update.
// RL6 - Keying enabled by one, else bypassed.
// RL7 - Keying auto or manual when enabled.
// RL8 - Automatic multi-device sync enable.
// RL9 - Manual sync advances once, then self-clears.
// RL10 - Amplitude dither enable.
// RL11 - Four phase dither enables, bits 19..16.
// RL12 - Update zeroes frequency accumulator once.
// RL13 - Update zeroes phase accumulator once.
// RL14 - Cosine when zero, sine when one.
// RL15 - Hold frequency accumulator cleared while set.
// RL16 - Hold phase accumulator cleared while set.
// RL17 - Serial data pin bidirectional or input-only.
// RL18 - Reset clears all; unlisted bits read zero. Bits 8, 7, 5, 4, 3 and 1 still read back; SDIO_OE_N resets to one.
// RL19 - Written values apply on update only.
module dcf_ctrl (
	input  wire logic                        CLK,
	input  wire logic                        ARST_N,
	input  wire logic                        WR_EN,
	input  wire logic [dcf_pkg::REG_W-1:0]   WR_DATA,
	output logic      [dcf_pkg::REG_W-1:0]   RD_DATA,
	input  wire logic                        IO_UPDATE,
	input  wire logic [dcf_pkg::SEL_W-1:0]   PROFILE_PINS,
	input  wire logic                        PROFILE_STEP,
	input  wire logic [dcf_pkg::MODE_W-1:0]  SEG_MODE,
	input  wire logic                        RAMP_TIMER_AT_ONE,
	input  wire logic                        SER_OUT_BIT,
	input  wire logic                        SER_OUT_EN,
	output logic                             SDIO_O,
	output logic                             SDIO_OE_N,
	output logic                             SDO_O,
	output dcf_pkg::dcf_core_type            CORE,
	output dcf_pkg::dcf_pulse_type           PULSE
);

	////////////////////////////////////////////////////////////////////////////////
	// State.

	typedef struct packed {
		logic [dcf_pkg::REG_W-1:0]  shadow;
		logic [dcf_pkg::REG_W-1:0]  active;
		logic                       upd_meta;
		logic                       upd_sync;
		logic                       upd_prev;
		logic [dcf_pkg::SEL_W-1:0]  pin_meta;
		logic [dcf_pkg::SEL_W-1:0]  pin_sync;
		logic [dcf_pkg::SEL_W-1:0]  loop_cnt;
		dcf_pkg::dcf_core_type      core;
		dcf_pkg::dcf_pulse_type     pulse;
		logic                       sdio_o;
		logic                       sdio_oe_n;
		logic                       sdo_o;
	} dcf_state_type;

	localparam dcf_state_type ST_RESET = '{
		shadow:    dcf_pkg::CFR_RESET_VAL,
		active:    dcf_pkg::CFR_RESET_VAL,
		upd_meta:  1'b0,
		upd_sync:  1'b0,
		upd_prev:  1'b0,
		pin_meta:  dcf_pkg::SEL_ZERO,
		pin_sync:  dcf_pkg::SEL_ZERO,
		loop_cnt:  dcf_pkg::SEL_ZERO,
		core:      '0,
		pulse:     '0,
		sdio_o:    1'b0,
		sdio_oe_n: 1'b1,
		sdo_o:     1'b0
	};

	dcf_state_type st_r;
	dcf_state_type st_nxt;

	logic                        upd;
	logic [dcf_pkg::REG_W-1:0]   cfg;
	logic [dcf_pkg::PROF_W-1:0]  prof_field;
	logic [dcf_pkg::SEL_W-1:0]   loop_lim;

	////////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		st_nxt = st_r;

		// The update pin and profile pins are asynchronous to this clock.
		st_nxt.upd_meta = IO_UPDATE;
		st_nxt.upd_sync = st_r.upd_meta;
		st_nxt.upd_prev = st_r.upd_sync;
		st_nxt.pin_meta = PROFILE_PINS;
		st_nxt.pin_sync = st_r.pin_meta;
		upd = st_r.upd_sync & ~st_r.upd_prev;

		// Writes only reach the buffer; the core sees them at the next update.
		if (WR_EN) begin
			st_nxt.shadow = WR_DATA & dcf_pkg::CFR_WR_MASK; // RL18
		end

		cfg = st_r.active;
		st_nxt.pulse = '0;
		if (upd) begin
			cfg = st_r.shadow; // RL19
			// The manual sync bit is acted on once and never stays set in the working copy;
			// the pulse is taken from the buffer, cleared below, so a later update does not advance the edge again.
			cfg[dcf_pkg::SW_SYNC_BIT] = 1'b0; // RL9
			st_nxt.active = cfg; // RL19
			st_nxt.pulse.sync_advance = st_r.shadow[dcf_pkg::SW_SYNC_BIT]; // RL9
			// A write of one in the same cycle as the self-clear is kept.
			if (!WR_EN) begin
				st_nxt.shadow[dcf_pkg::SW_SYNC_BIT] = 1'b0; // RL9
			end
			st_nxt.pulse.freq_acc_zero = cfg[dcf_pkg::AUTO_CLR_FREQ_BIT]; // RL12
			st_nxt.pulse.phase_acc_zero = cfg[dcf_pkg::AUTO_CLR_PH_BIT]; // RL13
		end

		// Timeout reload is always on; update reload only when selected.
		st_nxt.pulse.ramp_reload = RAMP_TIMER_AT_ONE
			| (upd & cfg[dcf_pkg::RAMP_LOAD_BIT]); // RL5

		////////////////////////////////////////////////////////////////////////
		// RAM and data path.

		st_nxt.core.ram_en = cfg[dcf_pkg::RAM_EN_BIT]; // RL1
		if (!cfg[dcf_pkg::RAM_EN_BIT]) begin
			st_nxt.core.src = dcf_pkg::DCF_SRC_TONE_SWEEP; // RL1
			st_nxt.core.ram_mode = '0; // RL1
		end else begin
			if (cfg[dcf_pkg::RAM_DEST_BIT]) begin
				st_nxt.core.src = dcf_pkg::DCF_SRC_RAM_PHASE; // RL3
			end else begin
				st_nxt.core.src = dcf_pkg::DCF_SRC_RAM_FREQ; // RL3
			end
			st_nxt.core.ram_mode = SEG_MODE; // RL2
		end

		////////////////////////////////////////////////////////////////////////
		// Profile selection.

		prof_field = cfg[dcf_pkg::PROF_HI:dcf_pkg::PROF_LO];
		// Only four profiles exist, so larger field values loop over all four.
		if (prof_field > dcf_pkg::PROF_W'(dcf_pkg::SEL_MAX)) begin
			loop_lim = dcf_pkg::SEL_MAX;
		end else begin
			loop_lim = prof_field[dcf_pkg::SEL_W-1:0];
		end
		st_nxt.core.int_prof = (prof_field != '0); // RL4
		if (prof_field == '0) begin
			st_nxt.loop_cnt = dcf_pkg::SEL_ZERO;
			st_nxt.core.prof_sel = st_r.pin_sync;
		end else begin
			if (PROFILE_STEP) begin
				if (st_r.loop_cnt >= loop_lim) begin
					st_nxt.loop_cnt = dcf_pkg::SEL_ZERO; // RL4
				end else begin
					st_nxt.loop_cnt = dcf_pkg::SEL_W'(st_r.loop_cnt + dcf_pkg::SEL_ONE); // RL4
				end
			end
			st_nxt.core.prof_sel = st_nxt.loop_cnt; // RL4
		end

		////////////////////////////////////////////////////////////////////////
		// Keying, sync, dither, waveform and accumulator clears.

		case ({cfg[dcf_pkg::OSK_EN_BIT], cfg[dcf_pkg::OSK_AUTO_BIT]})
			2'b10: begin
				st_nxt.core.osk = dcf_pkg::DCF_OSK_MANUAL; // RL7
			end
			2'b11: begin
				st_nxt.core.osk = dcf_pkg::DCF_OSK_AUTO; // RL7
			end
			default: begin
				st_nxt.core.osk = dcf_pkg::DCF_OSK_BYPASS; // RL6
			end
		endcase

		st_nxt.core.auto_sync_en = cfg[dcf_pkg::AUTO_SYNC_BIT]; // RL8
		st_nxt.core.amp_dither_en = cfg[dcf_pkg::AMP_DITH_BIT]; // RL10
		st_nxt.core.phase_dither_en = cfg[dcf_pkg::PH_DITH_HI:dcf_pkg::PH_DITH_LO]; // RL11
		st_nxt.core.sine_sel = cfg[dcf_pkg::SINE_BIT]; // RL14
		// These are levels: the core applies them to its accumulator clears.
		st_nxt.core.freq_acc_clr = cfg[dcf_pkg::CLR_FREQ_BIT]; // RL15
		st_nxt.core.phase_acc_clr = cfg[dcf_pkg::CLR_PH_BIT]; // RL16

		////////////////////////////////////////////////////////////////////////
		// Serial read-back pins.

		// In input-only mode the read data leaves on the separate output line
		// and the shared pin is never driven, avoiding contention with the host.
		if (cfg[dcf_pkg::SDIO_IN_ONLY_BIT]) begin
			st_nxt.sdio_oe_n = 1'b1; // RL17
			st_nxt.sdio_o = 1'b0;
			st_nxt.sdo_o = SER_OUT_BIT; // RL17
		end else begin
			st_nxt.sdio_oe_n = ~SER_OUT_EN; // RL17
			st_nxt.sdio_o = SER_OUT_BIT;
			st_nxt.sdo_o = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers.

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_r <= ST_RESET; // RL18
		end else begin
			st_r <= st_nxt;
		end
	end

	assign RD_DATA   = st_r.active;
	assign SDIO_O    = st_r.sdio_o;
	assign SDIO_OE_N = st_r.sdio_oe_n;
	assign SDO_O     = st_r.sdo_o;
	assign CORE      = st_r.core;
	assign PULSE     = st_r.pulse;

endmodule

// *** src/dcf_pkg.sv ***
package dcf_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Register geometry and reset.

	localparam int              REG_W         = 32;
	localparam logic [31:0]     CFR_RESET_VAL = 32'h0000_0000;
	// Control bits and the unused bits 8, 7, 5, 4, 3 and 1 are stored; positions 21, 15, 6, 2 and 0 read zero.
	localparam logic [31:0]     CFR_WR_MASK   = 32'hFFDF_7FBA;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions.

	localparam int RAM_EN_BIT        = 31;
	localparam int RAM_DEST_BIT      = 30;
	localparam int PROF_HI           = 29;
	localparam int PROF_LO           = 27;
	localparam int RAMP_LOAD_BIT     = 26;
	localparam int OSK_EN_BIT        = 25;
	localparam int OSK_AUTO_BIT      = 24;
	localparam int AUTO_SYNC_BIT     = 23;
	localparam int SW_SYNC_BIT       = 22;
	localparam int AMP_DITH_BIT      = 20;
	localparam int PH_DITH_HI        = 19;
	localparam int PH_DITH_LO        = 16;
	localparam int AUTO_CLR_FREQ_BIT = 14;
	localparam int AUTO_CLR_PH_BIT   = 13;
	localparam int SINE_BIT          = 12;
	localparam int CLR_FREQ_BIT      = 11;
	localparam int CLR_PH_BIT        = 10;
	localparam int SDIO_IN_ONLY_BIT  = 9;

	////////////////////////////////////////////////////////////////////////////////
	// Widths and limits.

	localparam int              PROF_W    = 3;
	localparam int              DITH_W    = 4;
	localparam int              MODE_W    = 3;
	localparam int              SEL_W     = 2;
	localparam logic [SEL_W-1:0] SEL_MAX  = 2'h3;
	localparam logic [SEL_W-1:0] SEL_ZERO = 2'h0;
	localparam logic [SEL_W-1:0] SEL_ONE  = 2'h1;

	////////////////////////////////////////////////////////////////////////////////
	// Types.

	typedef enum logic [1:0] {DCF_OSK_BYPASS, DCF_OSK_MANUAL, DCF_OSK_AUTO} dcf_osk_type;

	typedef enum logic [1:0] {DCF_SRC_TONE_SWEEP, DCF_SRC_RAM_FREQ, DCF_SRC_RAM_PHASE} dcf_src_type;

	typedef struct packed {
		logic                 ram_en;
		dcf_src_type          src;
		logic [MODE_W-1:0]    ram_mode;
		logic                 int_prof;
		logic [SEL_W-1:0]     prof_sel;
		dcf_osk_type          osk;
		logic                 auto_sync_en;
		logic                 amp_dither_en;
		logic [DITH_W-1:0]    phase_dither_en;
		logic                 sine_sel;
		logic                 freq_acc_clr;
		logic                 phase_acc_clr;
	} dcf_core_type;

	typedef struct packed {
		logic sync_advance;
		logic freq_acc_zero;
		logic phase_acc_zero;
		logic ramp_reload;
	} dcf_pulse_type;

endpackage
